// [logic/bms_gate_gen.sv]
// Complementary half-bridge gate generator with fixed deadtime.
`timescale 1ns/10ps
module bms_gate_gen
  import bms_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Sequencer link.
  bms_hb_if.gen hb
);
  bms_phase_t phase;
  bms_phase_t next_phase;
  logic [HP_W-1:0] cnt;
  logic [HP_W-1:0] on_time;
  logic [HP_W-1:0] next_cnt;
  logic phase_done;

  // Each on-phase is the half period minus one deadtime, so both sides get equal time.
  assign on_time = (hb.half_period > HP_W'(DEADTIME_CYC)) ? hb.half_period - HP_W'(DEADTIME_CYC) : HP_W'(1);
  assign phase_done = (cnt == '0);
  assign next_phase = !hb.en ? PH_DEAD_B : (phase_done ? bms_phase_t'(phase + 2'h1) : phase);
  // Deadtime loaded from the clock-derived constant at each turn-off.
  assign next_cnt = !hb.en ? '0 : !phase_done ? cnt - HP_W'(1) :
                    (next_phase == PH_DEAD_A || next_phase == PH_DEAD_B) ? HP_W'(DEADTIME_CYC - 1) :
                    on_time - HP_W'(1);

  // Phase sequencing and registered gate outputs.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= PH_DEAD_B;
      cnt <= '0;
      hb.low_gate <= 1'b0;
      hb.high_gate <= 1'b0;
      hb.cycle_end <= 1'b0;
    end else begin
      phase <= next_phase;
      cnt <= next_cnt;
      hb.low_gate <= hb.en && next_phase == PH_LOW_ON;
      hb.high_gate <= hb.en && hb.hs_allow && next_phase == PH_HIGH_ON;
      // Pulse two cycles before the next low phase, so a new half period is in place when it loads.
      hb.cycle_end <= hb.en && phase == PH_DEAD_B && cnt == HP_W'(2);
    end
  end

  // Deadtime check: after low turns off, high stays off for at least 16 cycles.
  sequence s_low_off;
    $fell(hb.low_gate);
  endsequence
  a_no_overlap_gap: assert property (@(posedge clk) disable iff (!reset_n)
    s_low_off |-> !hb.high_gate [*8] ##1 (!hb.high_gate [*8])) else $error("high gate on inside deadtime");
  a_gates_exclusive: assert property (@(posedge clk) disable iff (!reset_n)
    !(hb.low_gate && hb.high_gate)) else $error("both gates on");
  a_high_needs_boot: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(hb.high_gate) |-> $past(hb.hs_allow)) else $error("high gate without bootstrap");
  a_dead_load: assert property (@(posedge clk) disable iff (!reset_n)
    (hb.en && phase == PH_LOW_ON && phase_done) |=> (cnt == HP_W'(DEADTIME_CYC - 1))) else $error("deadtime load");
endmodule : bms_gate_gen

// [logic/bms_hb_if.sv]
// Link between the sequencer and its half-bridge gate generator.
`timescale 1ns/10ps
interface bms_hb_if;
  import bms_pkg::*;
  logic en;
  logic hs_allow;
  logic [HP_W-1:0] half_period;
  logic low_gate;
  logic high_gate;
  logic cycle_end;
  // Generator side.
  modport gen (input en, input hs_allow, input half_period, output low_gate, output high_gate, output cycle_end);
  // Sequencer side.
  modport ctl (output en, output hs_allow, output half_period, input low_gate, input high_gate, input cycle_end);
endinterface : bms_hb_if

// [logic/bms_pkg.sv]
// Shared constants and types for the ballast mode sequencer.
package bms_pkg;
  // Clock period and deadtime, each in its own unit.
  localparam int CLK_PERIOD_PS = 5000;
  localparam int DEADTIME_NS = 1600;
  // Least time, so the cycle count rounds up.
  localparam int DEADTIME_CYC = (DEADTIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Half-period widths and defaults, in clock cycles.
  localparam int HP_W = 16;
  localparam logic [15:0] HP_SOFT_START = 16'h03e8;
  localparam logic [15:0] HP_PREHEAT = 16'h07d0;
  localparam logic [15:0] HP_RUN = 16'h0bb8;
  localparam logic [15:0] HP_SS_STEP = 16'h0032;
  localparam logic [15:0] HP_IGN_STEP = 16'h0004;
  localparam logic [15:0] HP_REG_STEP = 16'h0008;
  // Over-current fault counter.
  localparam int OC_CNT_W = 7;
  localparam logic [6:0] OC_EVENT_LIMIT = 7'h41;
  localparam logic [6:0] OC_CNT_RESET = 7'h00;
  // Synchronised comparator bit positions.
  localparam int CMP_W = 7;
  localparam int CMP_SUPPLY_OK = 0;
  localparam int CMP_SD_RELEASED = 1;
  localparam int CMP_SD_HIGH = 2;
  localparam int CMP_BOOT_OK = 3;
  localparam int CMP_CPH_TWO_THIRDS = 4;
  localparam int CMP_CPH_ONE_THIRD = 5;
  localparam int CMP_CS_OVER = 6;
  // Operating modes.
  typedef enum logic [2:0] {
    ST_SUPPLY_LOCKOUT,
    ST_PREHEAT,
    ST_IGNITION,
    ST_RUN,
    ST_FAULT
  } bms_state_t;
  // Half-bridge phases.
  typedef enum logic [1:0] {
    PH_LOW_ON,
    PH_DEAD_A,
    PH_HIGH_ON,
    PH_DEAD_B
  } bms_phase_t;
endpackage : bms_pkg

// [logic/bms_sequencer.sv]
// Mode sequencer of a lamp ballast controller: lockout, preheat, ignition, run and fault.
`timescale 1ns/10ps
module bms_sequencer
  import bms_pkg::*;
#(
  parameter logic [HP_W-1:0] SOFT_START_HP = HP_SOFT_START,
  parameter logic [HP_W-1:0] PREHEAT_HP = HP_PREHEAT,
  parameter logic [HP_W-1:0] RUN_HP = HP_RUN,
  parameter logic [OC_CNT_W-1:0] EVENT_LIMIT = OC_EVENT_LIMIT
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Comparator results from the analog front end.
  input wire logic supply_start_ok,
  input wire logic shutdown_released,
  input wire logic shutdown_high,
  input wire logic highside_supply_ok,
  input wire logic preheat_timer_above_two_thirds,
  input wire logic preheat_timer_below_one_third,
  input wire logic overcurrent_sense,
  // Half-bridge gate commands.
  output logic low_side_gate,
  output logic high_side_gate,
  // Analog switches and enables.
  output logic osc_enable,
  output logic preheat_timer_discharge,
  output logic freq_select_switch,
  output logic pfc_high_gain,
  output logic overcurrent_count_enable,
  // Status.
  output logic fault_latched,
  output logic run_active
);
  bms_hb_if hb();
  logic [CMP_W-1:0] cmp_raw;
  logic [CMP_W-1:0] cmp;
  bms_state_t state;
  bms_state_t next_state;
  logic recharge;
  logic next_recharge;
  logic cs_hit;
  logic [OC_CNT_W-1:0] oc_cnt;
  logic [OC_CNT_W-1:0] next_oc_cnt;
  logic [HP_W-1:0] half_period;
  logic [HP_W-1:0] next_half_period;
  logic supply_ok;
  logic sd_released;
  logic sd_high;
  logic cph_hi;
  logic cph_lo;
  logic cs_over;
  logic oc_trip;
  logic in_lockout;
  logic in_preheat;
  logic in_ignition;
  logic in_run;
  logic in_fault;
  logic counting;
  logic [HP_W-1:0] hp_up_ss;
  logic [HP_W-1:0] hp_up_ign;
  logic [HP_W-1:0] hp_down_reg;
  logic highside_ok_seen;

  // Every comparator level is synchronised before any decision uses it.
  assign cmp_raw = {overcurrent_sense, preheat_timer_below_one_third, preheat_timer_above_two_thirds,
                    highside_supply_ok, shutdown_high, shutdown_released, supply_start_ok};
  bms_sync #(.W(CMP_W)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d(cmp_raw),
    .q(cmp)
  );

  // Named comparator views.
  assign supply_ok = cmp[CMP_SUPPLY_OK];
  assign sd_released = cmp[CMP_SD_RELEASED];
  assign sd_high = cmp[CMP_SD_HIGH];
  assign cph_hi = cmp[CMP_CPH_TWO_THIRDS];
  assign cph_lo = cmp[CMP_CPH_ONE_THIRD];
  assign cs_over = cmp[CMP_CS_OVER];

  // State decodes.
  assign in_lockout = (state == ST_SUPPLY_LOCKOUT);
  assign in_preheat = (state == ST_PREHEAT);
  assign in_ignition = (state == ST_IGNITION);
  assign in_run = (state == ST_RUN);
  assign in_fault = (state == ST_FAULT);
  assign counting = in_preheat || in_run;
  assign oc_trip = (oc_cnt >= EVENT_LIMIT);

  // Mode transitions; losing supply always returns to lockout.
  always_comb begin
    next_state = state;
    case (state)
      ST_SUPPLY_LOCKOUT: begin
        if (supply_ok && sd_released) begin
          next_state = ST_PREHEAT;
        end
      end
      ST_PREHEAT: begin
        if (oc_trip) begin
          next_state = ST_FAULT;
        end else if (cph_hi) begin
          next_state = ST_IGNITION;
        end
      end
      ST_IGNITION: begin
        if (recharge && cph_hi) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (oc_trip) begin
          next_state = ST_FAULT;
        end
      end
      ST_FAULT: begin
        next_state = ST_FAULT;
      end
      default: begin
        next_state = ST_SUPPLY_LOCKOUT;
      end
    endcase
    if (!supply_ok || sd_high) begin
      next_state = ST_SUPPLY_LOCKOUT;
    end
  end

  // Ignition first discharges the timer to one third, then lets it recharge.
  assign next_recharge = in_ignition && (recharge || cph_lo);

  // Over-current events during the low-side on-time, one verdict per low cycle.
  assign next_oc_cnt = !counting ? OC_CNT_RESET :
                       !hb.cycle_end ? oc_cnt :
                       cs_hit ? (oc_trip ? oc_cnt : oc_cnt + OC_CNT_W'(1)) :
                       (oc_cnt == OC_CNT_RESET ? OC_CNT_RESET : oc_cnt - OC_CNT_W'(1));

  // Frequency steering: soft-start ramp, ignition sweep, and current regulation.
  assign hp_up_ss = (half_period + HP_SS_STEP > PREHEAT_HP) ? PREHEAT_HP : half_period + HP_SS_STEP;
  assign hp_up_ign = (half_period + HP_IGN_STEP > RUN_HP) ? RUN_HP : half_period + HP_IGN_STEP;
  assign hp_down_reg = (half_period < PREHEAT_HP + HP_REG_STEP) ? PREHEAT_HP : half_period - HP_REG_STEP;
  assign next_half_period = in_lockout || in_fault ? SOFT_START_HP :
                            !hb.cycle_end ? half_period :
                            in_preheat ? hp_up_ss :
                            in_ignition ? (cs_hit ? hp_down_reg : hp_up_ign) :
                            RUN_HP;

  // Gate generator control.
  assign hb.en = in_preheat || in_ignition || in_run;
  assign hb.hs_allow = highside_ok_seen;
  assign hb.half_period = half_period;

  // Half-bridge gate generator.
  bms_gate_gen u_gate (
    .clk(clk),
    .reset_n(reset_n),
    .hb(hb.gen)
  );

  // Mode and bookkeeping registers.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_SUPPLY_LOCKOUT;
      recharge <= 1'b0;
      oc_cnt <= OC_CNT_RESET;
      half_period <= SOFT_START_HP;
      highside_ok_seen <= 1'b0;
    end else begin
      state <= next_state;
      recharge <= next_recharge;
      oc_cnt <= next_oc_cnt;
      half_period <= next_half_period;
      highside_ok_seen <= hb.en && (highside_ok_seen || cmp[CMP_BOOT_OK]);
    end
  end

  // Sticky over-current flag for the current low cycle; a new event wins over the clear.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_hit <= 1'b0;
    end else begin
      cs_hit <= ((hb.cycle_end ? 1'b0 : cs_hit) || (cs_over && hb.low_gate)) && hb.en;
    end
  end

  // Registered switch, enable and status outputs.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_enable <= 1'b0;
      preheat_timer_discharge <= 1'b1;
      freq_select_switch <= 1'b1;
      pfc_high_gain <= 1'b0;
      overcurrent_count_enable <= 1'b0;
      fault_latched <= 1'b0;
      run_active <= 1'b0;
    end else begin
      osc_enable <= hb.en;
      preheat_timer_discharge <= in_lockout || in_fault || (in_ignition && !next_recharge);
      freq_select_switch <= in_lockout || in_preheat || in_fault;
      pfc_high_gain <= in_preheat || in_ignition;
      overcurrent_count_enable <= counting;
      fault_latched <= in_fault;
      run_active <= in_run;
    end
  end

  // Gate outputs come straight from the generator's flip-flops.
  assign low_side_gate = hb.low_gate;
  assign high_side_gate = hb.high_gate;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);


  // Lockout is kept while the supply is low.
  a_lockout_held: assert property (in_lockout && !supply_ok |=> in_lockout) else $error("left lockout without supply");
  // Losing supply or a high shutdown input returns to lockout from any mode.
  a_forced_lockout: assert property (!supply_ok || sd_high |=> in_lockout)
    else $error("no return to lockout");

  // Lockout holds the bridge quiet and the timer discharged.
  a_lockout_outputs: assert property (in_lockout [*3] |-> !low_side_gate && !high_side_gate
    && preheat_timer_discharge && !osc_enable) else $error("lockout outputs wrong");

  // Supply good and shutdown released start preheat and free the timer.
  a_start_cond: assert property (in_lockout && supply_ok && sd_released && !sd_high |=> in_preheat
    ##2 !preheat_timer_discharge) else $error("start or discharge release wrong");

  // Preheat keeps the ramp input grounded, high gain and counting on.
  a_preheat_switch: assert property (in_preheat [*2] |-> freq_select_switch && pfc_high_gain
    && overcurrent_count_enable) else $error("preheat outputs wrong");

  // Soft start never runs slower than the preheat frequency.
  a_preheat_ramp: assert property (in_preheat |-> half_period <= PREHEAT_HP)
    else $error("preheat half period too long");

  // The first timer crossing ends preheat.
  a_preheat_exit: assert property (in_preheat && cph_hi && !oc_trip && supply_ok && !sd_high |=> in_ignition)
    else $error("preheat did not end");

  // Ignition entry closes the discharge switch and frees the ramp input.
  sequence s_ign_entry;
    $rose(in_ignition);
  endsequence
  a_ign_discharge: assert property (s_ign_entry |=> preheat_timer_discharge && !freq_select_switch)
    else $error("ignition entry outputs wrong");

  // An over-current cycle in ignition shortens the next half period.
  a_ign_regulate: assert property (in_ignition && hb.cycle_end && cs_hit && half_period >= PREHEAT_HP + HP_REG_STEP
    |=> half_period == $past(half_period) - HP_REG_STEP) else $error("no regulation step");

  // The second timer crossing enters run with counting on.
  a_run_entry: assert property (in_ignition && recharge && cph_hi && supply_ok && !sd_high |=> in_run
    ##1 overcurrent_count_enable) else $error("run entry wrong");

  // Run switches at the run frequency once a cycle has ended.
  a_run_freq: assert property (in_run && hb.cycle_end |=> half_period == RUN_HP)
    else $error("run half period wrong");

  // The event counter rests in ignition and steps down on clean cycles.
  a_count_off_ign: assert property (in_ignition |=> oc_cnt == OC_CNT_RESET || !in_ignition)
    else $error("counter live in ignition");
  a_count_down: assert property (counting && hb.cycle_end && !cs_hit && oc_cnt != OC_CNT_RESET
    |=> oc_cnt == $past(oc_cnt) - OC_CNT_W'(1)) else $error("counter did not decrement");

  // The event counter never passes its limit.
  a_count_limit: assert property (oc_cnt <= EVENT_LIMIT)
    else $error("counter above limit");

  // The high gate stays off until the bootstrap supply has been seen good.
  a_high_gate_wait: assert property (!highside_ok_seen |-> !high_side_gate)
    else $error("high gate before bootstrap good");

  // A full counter latches fault with both gates low.
  a_fault_latch: assert property (counting && oc_trip && supply_ok && !sd_high |=> in_fault
    ##2 !low_side_gate && !high_side_gate && fault_latched) else $error("fault not latched");
  // Fault is left only through lockout.
  a_fault_hold: assert property (in_fault && supply_ok && !sd_high |=> in_fault)
    else $error("fault left early");
endmodule : bms_sequencer

// [logic/bms_sync.sv]
// Two-flop synchroniser for a bundle of comparator levels.
`timescale 1ns/10ps
module bms_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Levels.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : bms_sync

// [verification/ballast_mode_sequencer_tb.sv]
// Self-checking bench for the ballast mode sequencer.
`timescale 1ns/10ps
module ballast_mode_sequencer_tb;
  import bms_pkg::*;
  localparam int IX_LOW = 0;
  localparam int IX_HIGH = 1;
  localparam int IX_OSC = 2;
  localparam int IX_DIS = 3;
  localparam int IX_FSEL = 4;
  localparam int IX_FAULT = 7;
  localparam int IX_RUN = 8;
  logic clk, reset_n, supply, sd_rel, sd_high, oc;
  logic hs_ok, above, below, cs;
  logic low_side_gate, high_side_gate, osc_enable, preheat_timer_discharge;
  logic freq_select_switch, pfc_high_gain, overcurrent_count_enable, fault_latched, run_active;
  logic [8:0] outs;
  logic flag;
  int n_errors, samples_checked, w1, w2, wa, wb, g;
  assign outs = {run_active, fault_latched, overcurrent_count_enable, pfc_high_gain, freq_select_switch,
                 preheat_timer_discharge, osc_enable, high_side_gate, low_side_gate};
  bms_sequencer #(.SOFT_START_HP(16'h0190), .PREHEAT_HP(16'h01f4), .RUN_HP(16'h0258), .EVENT_LIMIT(7'h04)) uut (
    .clk(clk), .reset_n(reset_n), .supply_start_ok(supply), .shutdown_released(sd_rel),
    .shutdown_high(sd_high), .highside_supply_ok(hs_ok), .preheat_timer_above_two_thirds(above),
    .preheat_timer_below_one_third(below), .overcurrent_sense(cs), .low_side_gate(low_side_gate),
    .high_side_gate(high_side_gate), .osc_enable(osc_enable), .preheat_timer_discharge(preheat_timer_discharge),
    .freq_select_switch(freq_select_switch), .pfc_high_gain(pfc_high_gain),
    .overcurrent_count_enable(overcurrent_count_enable), .fault_latched(fault_latched), .run_active(run_active));
  bms_bridge_model bridge (
    .clk(clk), .reset_n(reset_n), .low_side_gate(low_side_gate), .preheat_timer_discharge(preheat_timer_discharge),
    .oc_fault(oc), .highside_supply_ok(hs_ok), .above_two_thirds(above), .below_one_third(below),
    .overcurrent_sense(cs));
  // Free-running system clock.
  always #2.5 clk = ~clk;
  // The two gates must never be on together.
  always @(negedge clk) begin
    if (reset_n && low_side_gate === 1'b1 && high_side_gate === 1'b1) begin
      n_errors++;
      $display("[ERR] gate overlap expected 0 seen 1");
    end
  end
  task end_sim;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk
  // Waits for an output level under a bound; running out ends the run.
  task wait_on(input int i, input logic v, input int lim);
    int k;
    for (k = 0; k < lim && outs[i] !== v; k++) begin
      @(negedge clk);
    end
    if (outs[i] !== v) begin
      n_errors++;
      $display("[ERR] wait on output %0d expected %0h seen %0h", i, v, outs[i]);
      end_sim();
    end
  endtask : wait_on
  // Measures the next on-time of an output in cycles.
  task width(input int i, output int w);
    wait_on(i, 1'b1, 6000);
    w = 0;
    while (outs[i] === 1'b1 && w < 6000) begin
      @(negedge clk);
      w++;
    end
  endtask : width
  // Main sequence.
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    supply = 1'b0;
    sd_rel = 1'b1;
    sd_high = 1'b0;
    oc = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    chk("lockout outputs", 9'h018, outs);
    repeat (60) @(negedge clk);
    chk("lockout held", 9'h018, outs);
    sd_rel = 1'b0;
    supply = 1'b1;
    repeat (60) @(negedge clk);
    chk("shutdown holds", 9'h018, outs);
    sd_rel = 1'b1;
    repeat (2) @(negedge clk);
    chk("sync delay", 1'b0, osc_enable);
    wait_on(IX_OSC, 1'b1, 8);
    @(negedge clk);
    chk("preheat switches", 7'h1d, outs[8:2]);
    width(IX_LOW, w1);
    flag = 1'b0;
    repeat (600) begin
      @(negedge clk);
      flag = flag | high_side_gate;
    end
    chk("high gate waits", 1'b0, flag);
    width(IX_LOW, w2);
    chk("soft start", 1'b1, w1 < w2);
    g = 0;
    while (high_side_gate !== 1'b1 && g < 5000) begin
      @(negedge clk);
      g++;
    end
    chk("deadtime", 1'b1, g >= DEADTIME_CYC && g <= DEADTIME_CYC + 2);
    width(IX_HIGH, wa);
    chk("duty", w2, wa);
    wait_on(IX_FSEL, 1'b0, 20000);
    chk("end of preheat", 1'b1, above);
    @(negedge clk);
    chk("ignition switches", 7'h0b, outs[8:2]);
    wait_on(IX_DIS, 1'b0, 2000);
    chk("recharge", 1'b1, below);
    chk("ignition recharge", 7'h09, outs[8:2]);
    width(IX_LOW, wa);
    width(IX_LOW, wa);
    oc = 1'b1;
    width(IX_LOW, wb);
    width(IX_LOW, wb);
    chk("current regulation", 1'b1, wb < wa);
    repeat (3) width(IX_LOW, wb);
    oc = 1'b0;
    chk("counter off in ignition", 1'b0, fault_latched);
    wait_on(IX_RUN, 1'b1, 9000);
    @(negedge clk);
    chk("run switches", 7'h51, outs[8:2]);
    oc = 1'b1;
    repeat (3) width(IX_LOW, wb);
    oc = 1'b0;
    repeat (3) width(IX_LOW, wb);
    oc = 1'b1;
    repeat (3) width(IX_LOW, wb);
    chk("count down", 1'b0, fault_latched);
    wait_on(IX_FAULT, 1'b1, 4000);
    flag = 1'b0;
    repeat (2000) begin
      @(negedge clk);
      flag = flag | low_side_gate | high_side_gate;
    end
    chk("gates latched", 1'b0, flag);
    oc = 1'b0;
    supply = 1'b0;
    wait_on(IX_FAULT, 1'b0, 20);
    @(negedge clk);
    chk("back to lockout", 9'h018, outs);
    end_sim();
  end
endmodule : ballast_mode_sequencer_tb

// [verification/bms_bridge_model.sv]
// Behavioural half-bridge, bootstrap supply and preheat timer network.
`timescale 1ns/10ps
module bms_bridge_model #(
  parameter int TWO = 10000,
  parameter int ONE = 1000,
  parameter int TOP = 14000
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Commands from the sequencer.
  input wire logic low_side_gate,
  input wire logic preheat_timer_discharge,
  // Fault injection from the bench.
  input wire logic oc_fault,
  // Comparator results.
  output logic highside_supply_ok,
  output logic above_two_thirds,
  output logic below_one_third,
  output logic overcurrent_sense
);
  int cap;
  int boots;
  logic low_d;
  // The timer charges slowly when released and drains fast when shorted.
  // The bootstrap supply is good from the second low-side turn-on.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cap <= 0;
      boots <= 0;
      low_d <= 1'b0;
    end else begin
      if (preheat_timer_discharge) begin
        cap <= (cap > 20) ? cap - 20 : 0;
      end else if (cap < TOP) begin
        cap <= cap + 1;
      end
      if (low_side_gate && !low_d && boots < 2) begin
        boots <= boots + 1;
      end
      low_d <= low_side_gate;
    end
  end
  // Sense current flows only while the low-side switch conducts.
  assign highside_supply_ok = (boots >= 2);
  assign above_two_thirds = (cap > TWO);
  assign below_one_third = (cap < ONE);
  assign overcurrent_sense = oc_fault & low_side_gate;
endmodule : bms_bridge_model
